//--- hdl/cpu_subset_defs.vh
// Purpose: shared constants for the instruction subset datapath
// Assumes: included by bare name from the design files
// Notes: definitions only
`ifndef CPU_SUBSET_DEFS_VH
`define CPU_SUBSET_DEFS_VH

// Operation codes from the instruction decoder
`define OP_NOP 3'h0
`define OP_SUB_IMM_BORROW 3'h1
`define OP_READ_SPECIAL 3'h2
`define OP_WRITE_SPECIAL 3'h3
`define OP_HALT_ENTRY 3'h4
`define OP_REG_MINUS_ACC 3'h5
`define OP_NIBBLE_SWAP 3'h6

// Halt entry length in cycles, and its counter end value
`define HALT_CYCLES 3'h4
`define HALT_LAST 3'h3

// Destination select values
`define DEST_ACCUMULATOR 1'h0
`define DEST_FILE 1'h1

// Register byte offsets
`define ADDR_STATUS 4'h0
`define ADDR_ACCUM 4'h4
`define ADDR_CTRL 4'h8

// Status register field positions
`define ST_ZERO 0
`define ST_HALF_CARRY 1
`define ST_CARRY 2
`define ST_TIMEOUT 3
`define ST_POWER_DOWN 4
`define ST_HALTED 5
`define ST_BUSY 6

// Control register field positions
`define CTRL_WAKE 0
`define CTRL_FLAG_INIT 1

// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

// Reset values
`define RESET_TIMEOUT 1'h1
`define RESET_POWER_DOWN 1'h1
`define ZERO_BYTE 8'h00

`endif

//--- hdl/special_page_mem.v
// Purpose: special function page storage, one write and one read port
// Assumes: single clock, read data registered
// Notes: read address is sampled every edge, data valid one cycle later
module special_page_mem #(
    parameter DATA_WIDTH = 8,
    parameter INDEX_WIDTH = 4
) (
    input wire mclk,
    input wire reset,
    input wire wrEn,
    input wire [INDEX_WIDTH-1:0] wrIndex,
    input wire [DATA_WIDTH-1:0] wrData,
    input wire [INDEX_WIDTH-1:0] rdIndex,
    output reg [DATA_WIDTH-1:0] rdData
);
    reg [DATA_WIDTH-1:0] pageMem [0:(1<<INDEX_WIDTH)-1];

    // Storage has no reset; contents belong to the registers outside
    always @(posedge mclk) begin
        if (wrEn) begin
            pageMem[wrIndex] <= wrData;
        end
    end

    // Registered read, write-through so a write then read sees new data
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            rdData <= {DATA_WIDTH{1'b0}};
        end else if (wrEn && (wrIndex == rdIndex)) begin
            rdData <= wrData;
        end else begin
            rdData <= pageMem[rdIndex];
        end
    end
endmodule // special_page_mem

//--- hdl/cpu_instruction_subset.v
// Purpose: execute a subset of core instructions and expose state over AXI4-Lite
// Assumes: decoder holds instrValid and operands until instrReady is seen
// Notes: special page read lands in the accumulator one edge late, forwarded
//
// Summary of operation
// - sub_imm_with_borrow: imm + ~accumulator + carry to accumulator, flags set, one cycle
// - read_special_page copies indexed page register into accumulator, flags kept
// - write_special_page loads indexed page register from accumulator, nothing else
// - Halt entry clears watchdog counter and prescaler
// - Halt entry sets timeout, clears power down, halts, four cycles
// - reg_minus_accumulator: file register minus accumulator, flags set, one cycle
// - Destination bit 0 writes accumulator, 1 writes back file register
// - nibble_swap exchanges nibbles of file register, flags untouched, one cycle
`include "cpu_subset_defs.vh"
module cpu_instruction_subset #(
    parameter FILE_ADDR_WIDTH = 6,
    parameter PAGE_INDEX_WIDTH = 4
) (
    input wire mclk,
    input wire reset,
    input wire instrValid,
    output wire instrReady,
    input wire [2:0] opCode,
    input wire [7:0] immData,
    input wire [FILE_ADDR_WIDTH-1:0] fileAddr,
    input wire destSel,
    input wire [PAGE_INDEX_WIDTH-1:0] pageIndex,
    input wire [7:0] fileRdData,
    output reg fileWrEn,
    output reg [FILE_ADDR_WIDTH-1:0] fileWrAddr,
    output reg [7:0] fileWrData,
    output reg watchdogClear,
    output reg [7:0] accumulator,
    output reg halted,
    input wire wakeUp,
    input wire [3:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready
);
    // Subtract as a + ~b + cin; returns {carry, half carry, result}
    function [9:0] subCore;
        input [7:0] a;
        input [7:0] b;
        input cin;
        reg [8:0] full;
        reg [4:0] low;
        begin
            full = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
            low = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
            subCore = {full[8], low[4], full[7:0]};
        end
    endfunction

    reg zeroFlag;
    reg halfCarryFlag;
    reg carryFlag;
    reg timeoutFlag;
    reg powerDownFlag;
    reg haltBusy;
    reg [2:0] haltCount;
    reg pageLoadPend;
    wire [7:0] pageRdData;
    wire pageWrEn;
    wire [7:0] accumulatorNow;
    wire take;
    reg [9:0] subOut;
    reg isSub;
    reg ctrlWriteDone;
    reg [31:0] ctrlWriteData;
    reg ctrlWriteHit;

    assign instrReady = !haltBusy && !halted;
    assign take = instrValid && instrReady;
    // Forward page data still on its way to the accumulator
    assign accumulatorNow = pageLoadPend ? pageRdData : accumulator;
    assign pageWrEn = take && (opCode == `OP_WRITE_SPECIAL);

    special_page_mem #(
        .DATA_WIDTH(8),
        .INDEX_WIDTH(PAGE_INDEX_WIDTH)
    ) pageMem (
        .mclk(mclk),
        .reset(reset),
        .wrEn(pageWrEn),
        .wrIndex(pageIndex),
        .wrData(accumulatorNow),
        .rdIndex(pageIndex),
        .rdData(pageRdData)
    );

    // Subtract operand selection; reg minus acc has no incoming borrow
    always @* begin
        isSub = 1'b0;
        subOut = subCore(immData, accumulatorNow, carryFlag);
        if (take && opCode == `OP_SUB_IMM_BORROW) begin
            isSub = 1'b1;
        end else if (take && opCode == `OP_REG_MINUS_ACC) begin
            isSub = 1'b1;
            subOut = subCore(fileRdData, accumulatorNow, 1'b1);
        end
    end

    // Execution of one instruction per accepted cycle
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            accumulator <= `ZERO_BYTE;
            zeroFlag <= 1'b0;
            halfCarryFlag <= 1'b0;
            carryFlag <= 1'b0;
            fileWrEn <= 1'b0;
            fileWrAddr <= {FILE_ADDR_WIDTH{1'b0}};
            fileWrData <= `ZERO_BYTE;
            pageLoadPend <= 1'b0;
        end else begin
            fileWrEn <= 1'b0;
            pageLoadPend <= 1'b0;
            if (pageLoadPend) begin
                accumulator <= pageRdData;
            end
            if (isSub) begin
                carryFlag <= subOut[9];
                halfCarryFlag <= subOut[8];
                zeroFlag <= (subOut[7:0] == `ZERO_BYTE);
            end
            if (take) begin
                case (opCode)
                    `OP_SUB_IMM_BORROW: begin
                        accumulator <= subOut[7:0];
                    end
                    `OP_READ_SPECIAL: begin
                        pageLoadPend <= 1'b1;
                    end
                    `OP_REG_MINUS_ACC, `OP_NIBBLE_SWAP: begin
                        // Swap needs no flag path, result goes by destination
                        if (destSel == `DEST_ACCUMULATOR) begin
                            accumulator <= (opCode == `OP_NIBBLE_SWAP) ?
                                {fileRdData[3:0], fileRdData[7:4]} : subOut[7:0];
                        end else begin
                            fileWrEn <= 1'b1;
                            fileWrAddr <= fileAddr;
                            fileWrData <= (opCode == `OP_NIBBLE_SWAP) ?
                                {fileRdData[3:0], fileRdData[7:4]} : subOut[7:0];
                        end
                    end
                    default: begin
                        // Halt and write to page leave accumulator alone
                    end
                endcase
            end
        end
    end

    // Halt entry sequence, four cycles before the chip counts as halted
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            haltBusy <= 1'b0;
            haltCount <= 3'h0;
            halted <= 1'b0;
            watchdogClear <= 1'b0;
            timeoutFlag <= `RESET_TIMEOUT;
            powerDownFlag <= `RESET_POWER_DOWN;
        end else begin
            watchdogClear <= 1'b0;
            if (take && opCode == `OP_HALT_ENTRY) begin
                haltBusy <= 1'b1;
                haltCount <= 3'h0;
                watchdogClear <= 1'b1;
            end else if (haltBusy) begin
                haltCount <= haltCount + 3'h1;
                if (haltCount == `HALT_LAST - 3'h1) begin
                    haltBusy <= 1'b0;
                    halted <= 1'b1;
                    timeoutFlag <= 1'b1;
                    powerDownFlag <= 1'b0;
                end
            end else if (halted && (wakeUp || (ctrlWriteHit && ctrlWriteData[`CTRL_WAKE]))) begin
                halted <= 1'b0;
            end
            // Software restores power-on flag values, halt sequence wins
            if (ctrlWriteHit && ctrlWriteData[`CTRL_FLAG_INIT] && !haltBusy) begin
                timeoutFlag <= `RESET_TIMEOUT;
                powerDownFlag <= `RESET_POWER_DOWN;
            end
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    reg awHeld;
    reg wHeld;
    reg [3:0] awAddrReg;
    reg [31:0] wDataReg;
    reg [3:0] wStrbReg;
    wire awNow;
    wire wNow;
    wire [3:0] wrAddr;
    assign s_axi_awready = !awHeld && !s_axi_bvalid;
    assign s_axi_wready = !wHeld && !s_axi_bvalid;
    assign awNow = awHeld || s_axi_awvalid;
    assign wNow = wHeld || s_axi_wvalid;
    assign wrAddr = awHeld ? awAddrReg : s_axi_awaddr;

    // Write decode combined into one pulse for the control register
    always @* begin
        ctrlWriteData = wHeld ? wDataReg : s_axi_wdata;
        ctrlWriteDone = awNow && wNow && !s_axi_bvalid;
        ctrlWriteHit = ctrlWriteDone && (wrAddr == `ADDR_CTRL) &&
            (wHeld ? wStrbReg[0] : s_axi_wstrb[0]);
    end

    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddrReg <= 4'h0;
            wDataReg <= 32'h0;
            wStrbReg <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (ctrlWriteDone) begin
                awHeld <= 1'b0;
                wHeld <= 1'b0;
                s_axi_bvalid <= 1'b1;
                // Status and accumulator are read only; writes there are refused
                s_axi_bresp <= (wrAddr == `ADDR_CTRL) ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                if (s_axi_awvalid && s_axi_awready) begin
                    awHeld <= 1'b1;
                    awAddrReg <= s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready) begin
                    wHeld <= 1'b1;
                    wDataReg <= s_axi_wdata;
                    wStrbReg <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // AXI4-Lite read side, one cycle answer
    assign s_axi_arready = !s_axi_rvalid;
    always @(posedge mclk or posedge reset) begin
        if (reset) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            s_axi_rdata <= 32'h0;
            case (s_axi_araddr)
                `ADDR_STATUS: begin
                    s_axi_rdata[`ST_ZERO] <= zeroFlag;
                    s_axi_rdata[`ST_HALF_CARRY] <= halfCarryFlag;
                    s_axi_rdata[`ST_CARRY] <= carryFlag;
                    s_axi_rdata[`ST_TIMEOUT] <= timeoutFlag;
                    s_axi_rdata[`ST_POWER_DOWN] <= powerDownFlag;
                    s_axi_rdata[`ST_HALTED] <= halted;
                    s_axi_rdata[`ST_BUSY] <= haltBusy;
                end
                `ADDR_ACCUM: begin
                    s_axi_rdata[7:0] <= accumulatorNow;
                end
                `ADDR_CTRL: begin
                    s_axi_rdata <= 32'h0; // Control bits are pulses
                end
                default: begin
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule // cpu_instruction_subset

//--- tb/cpu_subset_sva.sv
// Purpose: concurrent checks on the instruction port of the subset datapath
// Assumes: one clock, reset asynchronous and active high
// Notes: the accumulator port lags one edge after a page read, so that take is skipped
`include "cpu_subset_defs.vh"
module cpu_subset_sva #(
    parameter FILE_ADDR_WIDTH = 6
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic instrValid,
    input wire logic instrReady,
    input wire logic [2:0] opCode,
    input wire logic [7:0] immData,
    input wire logic [FILE_ADDR_WIDTH-1:0] fileAddr,
    input wire logic destSel,
    input wire logic [7:0] fileRdData,
    input wire logic fileWrEn,
    input wire logic [FILE_ADDR_WIDTH-1:0] fileWrAddr,
    input wire logic [7:0] fileWrData,
    input wire logic watchdogClear,
    input wire logic [7:0] accumulator,
    input wire logic halted,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);
    logic lateLoad;
    logic [7:0] rdQ;
    // Takes per operation
    wire take = instrValid && instrReady && !lateLoad;
    wire tHalt = take && opCode == `OP_HALT_ENTRY;
    wire tSub = take && opCode == `OP_SUB_IMM_BORROW;
    wire tRma = take && opCode == `OP_REG_MINUS_ACC;
    wire tSwap = take && opCode == `OP_NIBBLE_SWAP;
    wire tWsp = take && opCode == `OP_WRITE_SPECIAL;
    // Operand kept one edge, results land at the take edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            lateLoad <= 1'b0;
            rdQ <= 8'h00;
        end else begin
            lateLoad <= instrValid && instrReady && opCode == `OP_READ_SPECIAL;
            rdQ <= fileRdData;
        end
    end
    // Clear pulse comes right after the take edge, not some cycles later
    halt_clear_a: assert property (tHalt |=> watchdogClear)
        else $error("watchdog clear missing");
    halt_seq_a: assert property (tHalt |=> (!instrReady && !halted)[*3] ##1 halted)
        else $error("halt entry timing wrong");
    halt_hold_a: assert property (halted |-> !instrReady)
        else $error("ready while halted");
    sub_imm_a: assert property (tSub |=>
        accumulator == $past(immData) - $past(accumulator) ||
        accumulator == $past(immData) + ~$past(accumulator)) else $error("borrow sub wrong");
    rma_accum_a: assert property (tRma && !destSel |=>
        accumulator == rdQ - $past(accumulator) && !fileWrEn) else $error("sub to accumulator bad");
    rma_file_a: assert property (tRma && destSel |=> fileWrEn &&
        fileWrData == rdQ - $past(accumulator) && $stable(accumulator)) else $error("sub wb wrong");
    swap_accum_a: assert property (tSwap && !destSel |=>
        accumulator == {rdQ[3:0], rdQ[7:4]} && !fileWrEn) else $error("swap to accumulator bad");
    swap_file_a: assert property (tSwap && destSel |=> fileWrEn &&
        fileWrData == {rdQ[3:0], rdQ[7:4]} && fileWrAddr == $past(fileAddr)) else $error("swap wb");
    page_write_a: assert property (tWsp |=> $stable(accumulator) && !fileWrEn)
        else $error("page write disturbed state");
    // Main scenarios reached
    cover property (tHalt);
    cover property (tSwap && destSel);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule // cpu_subset_sva
bind cpu_instruction_subset cpu_subset_sva #(.FILE_ADDR_WIDTH(FILE_ADDR_WIDTH)) sva_u (
    .mclk, .reset, .instrValid, .instrReady, .opCode, .immData, .fileAddr, .destSel,
    .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData, .watchdogClear, .accumulator,
    .halted, .s_axi_bvalid, .s_axi_bready);

//--- tb/cpu_instruction_subset_test.sv
// Purpose: self-checking bench for the instruction subset datapath
// Assumes: bench plays decoder, file registers and AXI4-Lite master
// Notes: flags are seen only through the status register
`include "cpu_subset_defs.vh"
module cpu_instruction_subset_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, reset, instrValid, destSel, wakeUp, w;
    logic [2:0] opCode;
    logic [7:0] immData, fileRdData;
    logic [5:0] fileAddr;
    logic [3:0] pageIndex, s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic [31:0] s_axi_wdata, d;
    logic [1:0] r;
    wire instrReady, fileWrEn, watchdogClear, halted, s_axi_awready, s_axi_wready;
    wire s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire [5:0] fileWrAddr;
    wire [7:0] fileWrData, accumulator;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    int numErrors = 0;
    int totalChecks = 0;
    cpu_instruction_subset dut_u (.mclk, .reset, .instrValid, .instrReady, .opCode, .immData,
        .fileAddr, .destSel, .pageIndex, .fileRdData, .fileWrEn, .fileWrAddr, .fileWrData,
        .watchdogClear, .accumulator, .halted, .wakeUp, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // 25 MHz clock
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        totalChecks++;
        if (seen !== exp) begin
            numErrors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic printVerdict;
        $display("checks %0d errors %0d", totalChecks, numErrors);
        if (numErrors == 0 && totalChecks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // A used-up wait bound ends the run
    task automatic limit(input int n);
        if (n >= 50) begin
            numErrors++;
            printVerdict();
        end
    endtask
    // Decoder side: hold the request until an edge with ready high takes it
    task automatic ins(input logic [2:0] op, input logic [7:0] imm, input logic ds,
        input logic [7:0] rdv, input logic [5:0] adr);
        int n;
        @(posedge mclk);
        opCode <= op;
        immData <= imm;
        destSel <= ds;
        fileRdData <= rdv;
        fileAddr <= adr;
        pageIndex <= adr[3:0];
        instrValid <= 1'b1;
        @(negedge mclk);
        for (n = 0; n < 50 && !instrReady; n++) @(negedge mclk);
        limit(n);
        @(posedge mclk);
        instrValid <= 1'b0;
        #1;
    endtask
    // One AXI4-Lite write (wr high) or read; address and data offered together
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] v);
        int n;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        @(negedge mclk);
        for (n = 0; n < 50 && !(wr ? s_axi_awready && s_axi_wready : s_axi_arready); n++)
            @(negedge mclk);
        limit(n);
        @(posedge mclk);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_bready <= wr;
        s_axi_rready <= !wr;
        @(negedge mclk);
        for (n = 0; n < 50 && !(wr ? s_axi_bvalid : s_axi_rvalid); n++) @(negedge mclk);
        limit(n);
        r = wr ? s_axi_bresp : s_axi_rresp;
        d = s_axi_rdata;
        @(posedge mclk);
        s_axi_bready <= 1'b0;
        s_axi_rready <= 1'b0;
    endtask
    // Status read; busy bit included, it is low whenever the bench looks
    task automatic st(input logic [31:0] e);
        bus(1'b0, `ADDR_STATUS, 32'h0);
        chk("status", d, e);
    endtask
    initial begin
        {instrValid, destSel, wakeUp, opCode, immData, fileRdData, fileAddr, pageIndex} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {s_axi_bready, s_axi_rready, s_axi_wdata} = '0;
        s_axi_wstrb = 4'hf;
        reset = 1'b1;
        repeat (6) @(posedge mclk);
        reset <= 1'b0;
        st(32'h18);
        ins(`OP_NIBBLE_SWAP, 8'h00, 1'b0, 8'h60, 6'h00);
        chk("accumulator", accumulator, 8'h06);
        ins(`OP_SUB_IMM_BORROW, 8'h05, 1'b0, 8'h00, 6'h00);
        chk("accumulator", accumulator, 8'hfe);
        st(32'h18);
        // Immediate 6 minus accumulator 5 twice, carry clear then set
        for (int k = 0; k < 2; k++) begin
            ins(`OP_NIBBLE_SWAP, 8'h00, 1'b0, 8'h50, 6'h00);
            ins(`OP_SUB_IMM_BORROW, 8'h06, 1'b0, 8'h00, 6'h00);
            chk("accumulator", accumulator, k[7:0]);
            st(k ? 32'h1e : 32'h1f);
        end
        ins(`OP_REG_MINUS_ACC, 8'h00, `DEST_FILE, 8'h05, 6'h3f);
        chk("wb", {fileWrEn, fileWrAddr, fileWrData, accumulator}, 23'h7f0401);
        st(32'h1e);
        ins(`OP_REG_MINUS_ACC, 8'h00, `DEST_ACCUMULATOR, 8'h00, 6'h01);
        chk("accumulator", {fileWrEn, accumulator}, 9'h0ff);
        st(32'h18);
        ins(`OP_REG_MINUS_ACC, 8'h00, `DEST_FILE, 8'hff, 6'h05);
        chk("wb", {fileWrEn, fileWrAddr, fileWrData, accumulator}, 23'h4500ff);
        st(32'h1f);
        ins(`OP_NIBBLE_SWAP, 8'h00, `DEST_FILE, 8'ha5, 6'h2a);
        chk("wb", {fileWrEn, fileWrAddr, fileWrData, accumulator}, 23'h6a5aff);
        st(32'h1f);
        ins(`OP_WRITE_SPECIAL, 8'h00, 1'b0, 8'h00, 6'h0f);
        chk("accumulator", {fileWrEn, accumulator}, 9'h0ff);
        ins(`OP_NIBBLE_SWAP, 8'h00, 1'b0, 8'h12, 6'h00);
        ins(`OP_WRITE_SPECIAL, 8'h00, 1'b0, 8'h00, 6'h00);
        ins(`OP_READ_SPECIAL, 8'h00, 1'b0, 8'h00, 6'h0f);
        bus(1'b0, `ADDR_ACCUM, 32'h0);
        chk("accumulatorReg", d, 32'hff);
        chk("accumulator", accumulator, 8'hff);
        st(32'h1f);
        ins(`OP_READ_SPECIAL, 8'h00, 1'b0, 8'h00, 6'h00);
        @(posedge mclk);
        #1;
        chk("accumulator", accumulator, 8'h21);
        // Halt entry: clear pulse, then halted after four cycles
        ins(`OP_HALT_ENTRY, 8'h00, 1'b0, 8'h00, 6'h00);
        w = watchdogClear;
        @(posedge mclk);
        #1;
        w = w | watchdogClear;
        @(posedge mclk);
        #1;
        chk("halt", {w, halted, instrReady}, 3'h4);
        @(posedge mclk);
        #1;
        chk("halted", halted, 1'h1);
        st(32'h2f);
        bus(1'b1, `ADDR_CTRL, 32'h1);
        chk("wake", {r, halted}, 3'h0);
        ins(`OP_HALT_ENTRY, 8'h00, 1'b0, 8'h00, 6'h00);
        repeat (4) @(posedge mclk);
        wakeUp <= 1'b1;
        repeat (2) @(posedge mclk);
        wakeUp <= 1'b0;
        chk("wakePin", halted, 1'h0);
        bus(1'b1, `ADDR_CTRL, 32'h2);
        st(32'h1f);
        bus(1'b1, `ADDR_STATUS, 32'h5);
        chk("roResp", r, `RESP_SLVERR);
        bus(1'b0, 4'hc, 32'h0);
        // Response and data compared apart; a joined value would lose the response bits
        chk("badRdResp", r, `RESP_SLVERR);
        chk("badRdData", d, 32'h0);
        printVerdict();
    end
endmodule // cpu_instruction_subset_test
